// [shared/liu_map.svh]
/*
 * Constants of the eight-channel system data interface: offsets,
 * symbol codes and timing counts.
 * Assumes a 250 MHz core clock and a plain strobe register port.
 */
// Notes on behaviour
// - Every channel has its own transmit and receive data and clock path.
// - Single rail: transmit NRZ data is captured on the active transmit clock edge.
// - A per-channel bit picks the rising or falling transmit clock edge.
// - Single rail: captured data is AMI, HDB3 or B8ZS encoded toward the line.
// - Dual rail: rails 00 and 11 give space, 01 positive, 10 negative pulse.
// - A missing transmit clock is flagged and interrupts unless masked.
// - Single rail: received pulses are decoded to NRZ with the chosen line code.
// - A per-channel bit inverts the single-rail receive data output.
// - Single rail: the code violation output reports received violations.
// - HDB3 or B8ZS: line code violations appear on the violation output.
// - AMI: bipolar violations appear on the violation output.
// - Dual rail with recovery: rails follow pulse polarity, level selectable.
// - With recovery on, receive outputs change on the selectable active receive clock edge; with it off they follow the rails.
// - With recovery on, the receive clock is recovered from the line pulses.
// - With recovery off, the receive clock is the XOR of the sliced rails.
// - Under loss of signal, a select bit routes the master reference out.
// - Lost transmit clock disables the driver unless looping back or patterning.
`ifndef LIU_MAP_SVH
`define LIU_MAP_SVH

`define CLK_NS 4
`define CLK_KHZ 250000
`define E1_KHZ 2048
`define T1_KHZ 1544
`define BIT_CYC_E1 (`CLK_KHZ / `E1_KHZ)
`define BIT_CYC_T1 (`CLK_KHZ / `T1_KHZ)
`define TX_MISS_NS 2000
`define TX_MISS_CYC ((`TX_MISS_NS + `CLK_NS - 1) / `CLK_NS)
`define PH_W 8

`define SYM_SPACE 2'h0
`define SYM_POS 2'h1
`define SYM_NEG 2'h2
`define SYM_MARK 2'h3

`define REG_DUAL 8'h00
`define REG_TX_EDGE 8'h04
`define REG_RX_INV 8'h08
`define REG_RX_EDGE 8'h0C
`define REG_CDR_EN 8'h10
`define REG_LINE_CODE 8'h14
`define REG_E1_SEL 8'h18
`define REG_MAINT 8'h1C
`define REG_IRQ_MASK 8'h20
`define REG_STATUS 8'h24

`endif

// [shared/liu_pkg.sv]
/*
 * Types shared by the system data interface and its transmit channel.
 * Assumes liu_map.svh on the include path.
 */
`include "liu_map.svh"
package liu_pkg;
    typedef enum logic [1:0] {CODE_AMI, CODE_HDB3, CODE_B8ZS, CODE_RSVD} line_code_type;

    typedef struct packed {
        logic [2:0] pos_s;
        logic [2:0] neg_s;
        logic pos_f;
        logic neg_f;
        logic [`PH_W-1:0] ph;
        logic got_pos;
        logic got_neg;
        logic [15:0] sym;
        logic [7:0] data;
        logic [7:0] vfl;
        logic have_mark;
        logic last_neg;
        logic have_v;
        logic v_neg;
        logic out_a;
        logic out_b;
        logic rclk;
    } rx_chan_type;
endpackage : liu_pkg

// [shared/liu_chan_if.sv]
/*
 * Signals between the interface top and one transmit channel.
 * Assumes all signals except the asynchronous transmit pins live on the core clock.
 */
`timescale 1ns/100ps
interface liu_chan_if;
    logic tclk_pin;
    logic tdat_pin;
    logic tneg_pin;
    logic dual;
    logic edge_fall;
    liu_pkg::line_code_type code;
    logic remote_lb;
    logic int_pat;
    logic mref_edge;
    logic [1:0] lb_sym;
    logic [1:0] line_sym;
    logic line_oe;
    logic clk_missing;
    modport top (output tclk_pin, tdat_pin, tneg_pin, dual, edge_fall, code, remote_lb,
        int_pat, mref_edge, lb_sym, input line_sym, line_oe, clk_missing);
    modport chan (input tclk_pin, tdat_pin, tneg_pin, dual, edge_fall, code, remote_lb,
        int_pat, mref_edge, lb_sym, output line_sym, line_oe, clk_missing);
endinterface : liu_chan_if

// [design/liu_chan.sv]
/*
 * One transmit channel: pin sampling, line encoding, missing clock watch.
 * Assumes transmit pins are asynchronous and config comes from the core clock.
 */
`timescale 1ns/100ps
`include "liu_map.svh"
module liu_chan #(
    parameter int MISS_CYC = `TX_MISS_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    liu_chan_if.chan bus
);
    localparam int MW = $clog2(MISS_CYC + 1);

    typedef struct packed {
        logic [2:0] clk_s;
        logic [2:0] dat_s;
        logic [2:0] neg_s;
        logic clk_f;
        logic [15:0] sym;
        logic last_neg;
        logic odd;
        logic [1:0] out;
        logic [MW-1:0] cnt;
        logic miss;
        logic oe;
    } tx_state_type;

    tx_state_type r;
    tx_state_type n;
    logic edge_tx;
    logic sample;
    logic [1:0] last_sym;

    // Change counts once stages two and three agree
    assign edge_tx = (r.clk_s[2] == r.clk_s[1]) && (r.clk_s[2] != r.clk_f)
        && (r.clk_s[2] != bus.edge_fall);
    assign sample = bus.int_pat ? bus.mref_edge : edge_tx;
    assign last_sym = r.last_neg ? `SYM_NEG : `SYM_POS;

    always_comb begin
        logic [15:0] s;
        logic [1:0] o;
        s = r.sym;
        o = `SYM_SPACE;
        n = r;
        n.clk_s = {r.clk_s[1:0], bus.tclk_pin};
        n.dat_s = {r.dat_s[1:0], bus.tdat_pin};
        n.neg_s = {r.neg_s[1:0], bus.tneg_pin};
        if (r.clk_s[2] == r.clk_s[1]) begin
            n.clk_f = r.clk_s[2];
        end
        if (edge_tx) begin
            n.cnt = '0;
            n.miss = 1'b0;
        end else if (r.cnt == MW'(MISS_CYC)) begin
            n.miss = 1'b1;
        end else begin
            n.cnt = r.cnt + 1'b1;
        end
        if (bus.remote_lb) begin
            n.out = bus.lb_sym;
        end else if (sample && bus.dual) begin
            case ({r.dat_s[2], r.neg_s[2]})
                2'b01: n.out = `SYM_POS;
                2'b10: n.out = `SYM_NEG;
                default: n.out = `SYM_SPACE;
            endcase
        end else if (sample) begin
            // Substitute at the output end, where sent polarity is known
            if (bus.code == liu_pkg::CODE_HDB3 && s[15:8] == '0) begin
                if (r.odd) begin
                    s[15:8] = {`SYM_SPACE, `SYM_SPACE, `SYM_SPACE, last_sym};
                end else begin
                    s[15:8] = {~last_sym, `SYM_SPACE, `SYM_SPACE, ~last_sym};
                end
            end else if (bus.code == liu_pkg::CODE_B8ZS && s == '0) begin
                s = {`SYM_SPACE, `SYM_SPACE, `SYM_SPACE, last_sym, ~last_sym,
                    `SYM_SPACE, ~last_sym, last_sym};
            end
            o = (s[15:14] == `SYM_MARK) ? ~last_sym : s[15:14];
            if (o != `SYM_SPACE) begin
                n.odd = (o == last_sym) ? 1'b0 : ~r.odd;
                n.last_neg = (o == `SYM_NEG);
            end
            n.out = o;
            n.sym = {s[13:0], (bus.int_pat | r.dat_s[2]) ? `SYM_MARK : `SYM_SPACE};
        end
        n.oe = !n.miss || bus.remote_lb || bus.int_pat;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.line_sym = r.out;
    assign bus.line_oe = r.oe;
    assign bus.clk_missing = r.miss;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    dual_space_a: assert property ((sample && bus.dual && !bus.remote_lb
        && r.dat_s[2] && r.neg_s[2]) |=> r.out == `SYM_SPACE) else $error("dual 11 not space");
    dual_pos_a: assert property ((sample && bus.dual && !bus.remote_lb
        && !r.dat_s[2] && r.neg_s[2]) |=> r.out == `SYM_POS) else $error("dual 01 not pos");
    miss_clear_a: assert property (edge_tx |=> !r.miss) else $error("miss after edge");
    miss_oe_a: assert property ((n.miss && !bus.remote_lb && !bus.int_pat)
        |=> !bus.line_oe) else $error("driver on without clock");
    ami_alt_a: assert property ((sample && !bus.dual && !bus.remote_lb
        && bus.code == liu_pkg::CODE_AMI && r.sym[15:14] == `SYM_MARK)
        |=> r.out == ($past(r.last_neg) ? `SYM_POS : `SYM_NEG)) else $error("AMI no alt");
    dual_cover_c: cover property (sample && bus.dual);
endmodule : liu_chan

// [design/liu_system_data_interface.sv]
/*
 * Eight-channel system data interface: register port, receive decode and
 * clock recovery, transmit channels, missing clock interrupt.
 * Assumes sliced rails, clocks and master reference arrive asynchronously,
 * and loss of signal comes from logic on the core clock.
 */
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "liu_map.svh"
module liu_system_data_interface #(
    parameter int N = 8,
    parameter int BIT_E1 = `BIT_CYC_E1,
    parameter int BIT_T1 = `BIT_CYC_T1,
    parameter int MISS_CYC = `TX_MISS_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic [N-1:0] I_TX_NRZ_IN,
    input wire logic [N-1:0] I_TX_NEG_RAIL_IN,
    input wire logic [N-1:0] I_TX_CLOCK_IN,
    input wire logic [N-1:0] I_RX_POS_SLICE,
    input wire logic [N-1:0] I_RX_NEG_SLICE,
    input wire logic [N-1:0] I_LOS,
    input wire logic I_MCLK_REF,
    output logic [N-1:0] O_RX_NRZ_OUT,
    output logic [N-1:0] O_CODE_VIOLATION_OUT,
    output logic [N-1:0] O_RX_CLOCK_OUT,
    output logic [N-1:0] O_LINE_POS,
    output logic [N-1:0] O_LINE_NEG,
    output logic [N-1:0] O_LINE_OE,
    output logic O_TCLK_MISS_IRQ
);
    typedef struct packed {
        logic [N-1:0] dual;
        logic [N-1:0] tx_fall;
        logic [N-1:0] rx_inv;
        logic [N-1:0] rx_fall;
        logic [N-1:0] cdr_en;
        logic [N-1:0] e1;
        logic [N-1:0] los_rclk;
        logic [N-1:0] rlb;
        logic [N-1:0] int_pat;
        logic [N-1:0] mask;
        logic [2*N-1:0] code;
        logic [31:0] rdata;
        logic [2:0] mref_s;
        logic mref_f;
        logic mref_edge;
        liu_pkg::rx_chan_type [N-1:0] rx;
    } state_type;

    state_type r;
    state_type n;
    logic [N-1:0][`PH_W-1:0] per;
    logic [N-1:0] rise_ev;
    logic [N-1:0] fall_ev;
    logic [N-1:0] upd_ev;
    logic [N-1:0] miss;

    // One full channel per lane
    generate
        for (genvar g = 0; g < N; g++) begin : ch
            liu_chan_if cif ();
            assign cif.tclk_pin = I_TX_CLOCK_IN[g];
            assign cif.tdat_pin = I_TX_NRZ_IN[g];
            assign cif.tneg_pin = I_TX_NEG_RAIL_IN[g];
            assign cif.dual = r.dual[g];
            assign cif.edge_fall = r.tx_fall[g];
            assign cif.code = liu_pkg::line_code_type'(r.code[2*g +: 2]);
            assign cif.remote_lb = r.rlb[g];
            assign cif.int_pat = r.int_pat[g];
            assign cif.mref_edge = r.mref_edge;
            assign cif.lb_sym = (r.rx[g].pos_f && r.rx[g].neg_f) ? `SYM_SPACE
                : {r.rx[g].neg_f, r.rx[g].pos_f};
            liu_chan #(
                .MISS_CYC(MISS_CYC)
            ) u_chan (
                .i_clk(I_CLK),
                .i_rst_n(I_RST_N),
                .bus(cif)
            );
            assign miss[g] = cif.clk_missing;
            assign O_LINE_POS[g] = cif.line_sym[0];
            assign O_LINE_NEG[g] = cif.line_sym[1];
            assign O_LINE_OE[g] = cif.line_oe;
            assign per[g] = r.e1[g] ? `PH_W'(BIT_E1) : `PH_W'(BIT_T1);
            assign rise_ev[g] = (r.rx[g].ph == per[g] - 1'b1);
            assign fall_ev[g] = (r.rx[g].ph == (per[g] >> 1) - 1'b1);
            assign upd_ev[g] = r.rx_fall[g] ? fall_ev[g] : rise_ev[g];
            assign O_RX_NRZ_OUT[g] = r.rx[g].out_a;
            assign O_CODE_VIOLATION_OUT[g] = r.rx[g].out_b;
            assign O_RX_CLOCK_OUT[g] = r.rx[g].rclk;
        end
    endgenerate

    assign O_RDATA = r.rdata;
    assign O_TCLK_MISS_IRQ = |(miss & ~r.mask);

    always_comb begin
        logic [1:0] s;
        logic m;
        logic pol;
        logic bpv;
        logic np;
        logic nn;
        logic inv;
        logic [1:0] cd;
        s = `SYM_SPACE;
        m = 1'b0;
        pol = 1'b0;
        bpv = 1'b0;
        np = 1'b0;
        nn = 1'b0;
        inv = 1'b0;
        cd = '0;
        n = r;
        n.rdata = '0;
        n.mref_s = {r.mref_s[1:0], I_MCLK_REF};
        if (r.mref_s[2] == r.mref_s[1]) begin
            n.mref_f = r.mref_s[2];
        end
        n.mref_edge = n.mref_f && !r.mref_f;

        // Register writes
        if (I_WR) begin
            if (I_ADDR == `REG_DUAL) begin
                n.dual = I_WDATA[N-1:0];
            end else if (I_ADDR == `REG_TX_EDGE) begin
                n.tx_fall = I_WDATA[N-1:0];
            end else if (I_ADDR == `REG_RX_INV) begin
                n.rx_inv = I_WDATA[N-1:0];
            end else if (I_ADDR == `REG_RX_EDGE) begin
                n.rx_fall = I_WDATA[N-1:0];
            end else if (I_ADDR == `REG_CDR_EN) begin
                n.cdr_en = I_WDATA[N-1:0];
            end else if (I_ADDR == `REG_LINE_CODE) begin
                n.code = I_WDATA[2*N-1:0];
            end else if (I_ADDR == `REG_E1_SEL) begin
                n.e1 = I_WDATA[N-1:0];
            end else if (I_ADDR == `REG_MAINT) begin
                n.los_rclk = I_WDATA[N-1:0];
                n.rlb = I_WDATA[2*N-1:N];
                n.int_pat = I_WDATA[3*N-1:2*N];
            end else if (I_ADDR == `REG_IRQ_MASK) begin
                n.mask = I_WDATA[N-1:0];
            end
        end

        // Register reads, answered next cycle
        if (I_RD) begin
            if (I_ADDR == `REG_DUAL) begin
                n.rdata = 32'(r.dual);
            end else if (I_ADDR == `REG_TX_EDGE) begin
                n.rdata = 32'(r.tx_fall);
            end else if (I_ADDR == `REG_RX_INV) begin
                n.rdata = 32'(r.rx_inv);
            end else if (I_ADDR == `REG_RX_EDGE) begin
                n.rdata = 32'(r.rx_fall);
            end else if (I_ADDR == `REG_CDR_EN) begin
                n.rdata = 32'(r.cdr_en);
            end else if (I_ADDR == `REG_LINE_CODE) begin
                n.rdata = 32'(r.code);
            end else if (I_ADDR == `REG_E1_SEL) begin
                n.rdata = 32'(r.e1);
            end else if (I_ADDR == `REG_MAINT) begin
                n.rdata = 32'({r.int_pat, r.rlb, r.los_rclk});
            end else if (I_ADDR == `REG_IRQ_MASK) begin
                n.rdata = 32'(r.mask);
            end else if (I_ADDR == `REG_STATUS) begin
                n.rdata = 32'({I_LOS, miss});
            end
        end

        // Receive path per channel
        for (int i = 0; i < N; i++) begin
            inv = r.rx_inv[i];
            cd = r.code[2*i +: 2];
            n.rx[i].pos_s = {r.rx[i].pos_s[1:0], I_RX_POS_SLICE[i]};
            n.rx[i].neg_s = {r.rx[i].neg_s[1:0], I_RX_NEG_SLICE[i]};
            if (r.rx[i].pos_s[2] == r.rx[i].pos_s[1]) begin
                n.rx[i].pos_f = r.rx[i].pos_s[2];
            end
            if (r.rx[i].neg_s[2] == r.rx[i].neg_s[1]) begin
                n.rx[i].neg_f = r.rx[i].neg_s[2];
            end
            np = n.rx[i].pos_f && !r.rx[i].pos_f;
            nn = n.rx[i].neg_f && !r.rx[i].neg_f;
            n.rx[i].ph = rise_ev[i] ? '0 : r.rx[i].ph + 1'b1;
            if ((np || nn) && !I_LOS[i]) begin
                n.rx[i].ph = per[i] >> 1;
            end
            if (rise_ev[i]) begin
                n.rx[i].got_pos = np;
                n.rx[i].got_neg = nn;
                if (r.rx[i].got_pos && !r.rx[i].got_neg) begin
                    s = `SYM_POS;
                end else if (r.rx[i].got_neg && !r.rx[i].got_pos) begin
                    s = `SYM_NEG;
                end else begin
                    s = `SYM_SPACE;
                end
                m = (s != `SYM_SPACE);
                pol = (s == `SYM_NEG);
                bpv = m && r.rx[i].have_mark && (pol == r.rx[i].last_neg);
                n.rx[i].sym = {r.rx[i].sym[13:0], s};
                n.rx[i].data = {r.rx[i].data[6:0], m};
                n.rx[i].vfl = {r.rx[i].vfl[6:0], bpv};
                if (m) begin
                    n.rx[i].have_mark = 1'b1;
                    n.rx[i].last_neg = pol;
                end
                if (cd == liu_pkg::CODE_HDB3 && bpv && n.rx[i].sym[5:2] == '0) begin
                    // 000V or B00V: substitution, not data
                    n.rx[i].data[3:0] = '0;
                    n.rx[i].vfl[0] = r.rx[i].have_v && (pol == r.rx[i].v_neg);
                    n.rx[i].have_v = 1'b1;
                    n.rx[i].v_neg = pol;
                end else if (cd == liu_pkg::CODE_B8ZS && n.rx[i].sym[15:10] == '0
                        && n.rx[i].sym[9:8] != `SYM_SPACE
                        && n.rx[i].sym[7:6] == ~n.rx[i].sym[9:8]
                        && n.rx[i].sym[5:4] == `SYM_SPACE
                        && n.rx[i].sym[3:2] == n.rx[i].sym[7:6]
                        && n.rx[i].sym[1:0] == n.rx[i].sym[9:8]) begin
                    n.rx[i].data = '0;
                    n.rx[i].vfl = '0;
                end
            end else begin
                n.rx[i].got_pos = r.rx[i].got_pos || np;
                n.rx[i].got_neg = r.rx[i].got_neg || nn;
            end

            if (I_LOS[i] && r.los_rclk[i]) begin
                n.rx[i].rclk = r.mref_f;
            end else if (!r.cdr_en[i]) begin
                n.rx[i].rclk = r.rx[i].pos_f ^ r.rx[i].neg_f;
            end else begin
                n.rx[i].rclk = (n.rx[i].ph < (per[i] >> 1));
            end
            if (!r.cdr_en[i]) begin
                n.rx[i].out_a = r.rx[i].pos_f ^ inv;
                n.rx[i].out_b = r.rx[i].neg_f ^ inv;
            end else if (upd_ev[i] && r.dual[i]) begin
                n.rx[i].out_a = r.rx[i].sym[0] ^ inv;
                n.rx[i].out_b = r.rx[i].sym[1] ^ inv;
            end else if (upd_ev[i]) begin
                n.rx[i].out_a = r.rx[i].data[7] ^ inv;
                n.rx[i].out_b = r.rx[i].vfl[7];
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            r <= '0;
            r.cdr_en <= '1;
            r.e1 <= '1;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    cdr_off_a: assert property ((!r.cdr_en[0] && !(I_LOS[0] && r.los_rclk[0]))
        |=> O_RX_CLOCK_OUT[0] == ($past(r.rx[0].pos_f) ^ $past(r.rx[0].neg_f)))
        else $error("rclk not rail xor");
    los_ref_a: assert property ((I_LOS[0] && r.los_rclk[0])
        |=> O_RX_CLOCK_OUT[0] == $past(r.mref_f)) else $error("rclk not master ref");
    rd_edge_a: assert property ((r.cdr_en[0] && $past(r.cdr_en[0]) && $changed(O_RX_NRZ_OUT[0])
        && $stable(r.rx_inv[0]) && $stable(r.dual[0])) |-> $past(upd_ev[0]))
        else $error("rx data moved off edge");
    irq_miss_a: assert property ((miss[0] && !r.mask[0]) |-> O_TCLK_MISS_IRQ)
        else $error("missing clock irq absent");
    rclk_fall_a: assert property ((r.cdr_en[0] && !I_LOS[0] && fall_ev[0])
        |=> !O_RX_CLOCK_OUT[0] ##1 !O_RX_CLOCK_OUT[0]) else $error("rclk low half wrong");
    ami_cv_a: assert property ((r.code[1:0] == liu_pkg::CODE_AMI && rise_ev[0]
        && r.rx[0].got_pos && !r.rx[0].got_neg && r.rx[0].have_mark && !r.rx[0].last_neg)
        |=> r.rx[0].vfl[0]) else $error("AMI bpv not flagged");
    pulse_cover_c: cover property (rise_ev[0] && r.rx[0].got_pos);
    irq_cover_c: cover property (O_TCLK_MISS_IRQ);
    cv_cover_c: cover property (r.cdr_en[0] && O_CODE_VIOLATION_OUT[0]);
endmodule : liu_system_data_interface

// [testbench/liu_framer_model.sv]
/*
 * Framer side of the transmit link: per-channel transmit clock and rails.
 * Assumes the bench sets run, dual and rail values between clock periods.
 */
`timescale 1ns/100ps
module liu_framer_model #(
    parameter int N = 8
) (
    input wire logic i_run,
    input wire logic i_dual,
    input wire logic [N-1:0] i_pos,
    input wire logic [N-1:0] i_neg,
    output logic [N-1:0] o_tclk,
    output logic [N-1:0] o_pos,
    output logic [N-1:0] o_neg
);
    logic clk_r;

    assign o_tclk = {N{clk_r}};

    initial begin
        clk_r = 1'b0;
        o_pos = '0;
        o_neg = '0;
        #3;
        forever begin
            #40;
            if (i_run) begin
                clk_r = ~clk_r; // 80 ns transmit clock
                if (!clk_r) begin
                    o_pos = i_pos;
                    o_neg = i_dual ? i_neg : '0; // Unused rail tied low
                end
            end else begin
                clk_r = 1'b0;
                o_pos = ~o_pos;
                o_neg = ~o_neg;
            end
        end
    end
endmodule : liu_framer_model

// [testbench/tb_top.sv]
/*
 * Self-checking bench: registers, dual rail transmit, missing clock, receive.
 * Assumes the design package, interface and map header are compiled first.
 */
`timescale 1ns/100ps
`include "liu_map.svh"
module tb_top;
    logic I_CLK = 0, I_RST_N = 0, I_WR = 0, I_RD = 0, I_MCLK_REF = 0, run = 0;
    logic [7:0] I_ADDR = 0, I_RX_POS_SLICE = 0, I_RX_NEG_SLICE = 0, pv = 0, nv = 0, los = 0;
    logic [31:0] I_WDATA = 0, rd_val;
    logic [7:0] I_TX_NRZ_IN, I_TX_NEG_RAIL_IN, I_TX_CLOCK_IN, rx_nrz, rx_cv, rx_clk, lp, ln, oe;
    logic irq;
    integer num_errors = 0, samples_checked = 0, seed = 32'hdbde, k;

    always #2 I_CLK = ~I_CLK;
    always #244 I_MCLK_REF = ~I_MCLK_REF;

    liu_framer_model i_liu_framer_model (.i_run(run), .i_dual(1'b1), .i_pos(pv),
        .i_neg(nv), .o_tclk(I_TX_CLOCK_IN), .o_pos(I_TX_NRZ_IN), .o_neg(I_TX_NEG_RAIL_IN));

    liu_system_data_interface #(.MISS_CYC(20)) i_liu_system_data_interface (.I_CLK(I_CLK),
        .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
        .O_RDATA(rd_val), .I_TX_NRZ_IN(I_TX_NRZ_IN), .I_TX_NEG_RAIL_IN(I_TX_NEG_RAIL_IN),
        .I_TX_CLOCK_IN(I_TX_CLOCK_IN), .I_RX_POS_SLICE(I_RX_POS_SLICE),
        .I_RX_NEG_SLICE(I_RX_NEG_SLICE), .I_LOS(los), .I_MCLK_REF(I_MCLK_REF),
        .O_RX_NRZ_OUT(rx_nrz), .O_CODE_VIOLATION_OUT(rx_cv), .O_RX_CLOCK_OUT(rx_clk),
        .O_LINE_POS(lp), .O_LINE_NEG(ln), .O_LINE_OE(oe), .O_TCLK_MISS_IRQ(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1 chk(rd_val, exp);
    endtask : rd

    task automatic stop_test;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        num_errors++;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        #1 chk(oe, 8'h00);
        rd(`REG_CDR_EN, 32'hFF);
        rd(`REG_E1_SEL, 32'hFF);
        rd(8'hFC, 32'h0);
        repeat (40) @(posedge I_CLK);
        rd(`REG_STATUS, 32'hFF);
        #1 chk(irq, 1'b1);
        wr(`REG_IRQ_MASK, 32'hFF);
        #1 chk(irq, 1'b0);
        wr(`REG_IRQ_MASK, 32'h0);
        k = $random(seed);
        wr(`REG_TX_EDGE, k);
        rd(`REG_TX_EDGE, k & 32'hFF);
        wr(`REG_TX_EDGE, 32'h0);
        wr(`REG_DUAL, 32'hFF);
        run <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            pv <= $random(seed);
            nv <= $random(seed);
            repeat (60) @(posedge I_CLK);
            chk(oe, 8'hFF);
            chk(lp, ~pv & nv);
            chk(ln, pv & ~nv);
        end
        run <= 1'b0;
        repeat (60) @(posedge I_CLK);
        chk(oe, 8'h00);
        rd(`REG_STATUS, 32'hFF);
        wr(`REG_CDR_EN, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(`REG_RX_INV, (i % 2) ? 32'hFF : 32'h0);
            I_RX_POS_SLICE <= $random(seed);
            I_RX_NEG_SLICE <= $random(seed);
            repeat (10) @(posedge I_CLK);
            chk(rx_clk, I_RX_POS_SLICE ^ I_RX_NEG_SLICE);
            chk(rx_nrz, I_RX_POS_SLICE ^ ((i % 2) ? 8'hFF : 8'h00));
        end
        wr(`REG_MAINT, 32'hFF);
        los <= 8'hFF;
        rd(`REG_STATUS, 32'hFFFF);
        @(posedge I_MCLK_REF);
        repeat (10) @(posedge I_CLK);
        chk(rx_clk, 8'hFF);
        @(negedge I_MCLK_REF);
        repeat (10) @(posedge I_CLK);
        chk(rx_clk, 8'h00);
        stop_test;
    end
endmodule : tb_top
